// ===== src/sog_pkg.sv
package sog_pkg;
	localparam int NUM_GEN = 4;
	localparam int GEN_W = 2;
	localparam int LEVELS = 6;
	localparam int CNT_W = 32;
	localparam int ADDR_W = 64;
	localparam int OFFREG_W = 5;
	localparam int LVL_W = 3;

	// addressing modes that may carry a generator reference
	localparam logic [2:0] MODE_SCALED = 3'h2;
	localparam logic [2:0] MODE_ADVANCE = 3'h6;
	// offset-register field: 00000..00011 select generators 0..3
	localparam logic [OFFREG_W-1:0] OFFREG_GEN_LAST = 5'h03;
	localparam logic [LVL_W-1:0] BRK_FULL = 3'h5;
	localparam logic [LVL_W-1:0] BRK_NONE = 3'h0;

	// APB register map (byte addresses)
	localparam int PADDR_W = 12;
	localparam logic [PADDR_W-1:0] REG_ACTIVE = 12'h000;
	localparam logic [PADDR_W-1:0] REG_IRQ_STAT = 12'h004;
	localparam logic [PADDR_W-1:0] REG_IRQ_MASK = 12'h008;
	localparam logic [PADDR_W-1:0] REG_FAULT_CNT = 12'h00C;
	localparam int IRQ_W = 2 * NUM_GEN;
	localparam int IRQ_FAULT_LSB = 0;
	localparam int IRQ_END_LSB = NUM_GEN;
	localparam logic [IRQ_W-1:0] IRQ_STAT_RST = 8'h00;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 8'h00;
	localparam logic [15:0] FAULT_CNT_RST = 16'h0000;

	typedef enum logic [1:0] {
		SOG_OP_NONE,
		SOG_OP_OPEN,
		SOG_OP_CLOSE,
		SOG_OP_BREAK
	} sog_op_t;

	typedef enum logic [2:0] {
		SOG_CLS_LOAD,
		SOG_CLS_STORE,
		SOG_CLS_ADDA,
		SOG_CLS_SUBA,
		SOG_CLS_OTHER
	} sog_cls_t;

	// generator template; reset value is all zero
	typedef struct packed {
		logic [2:0] vec_step;
		logic [2:0] dim_fmt;
		logic [LEVELS-1:1][CNT_W-1:0] dim;
		logic [LEVELS-1:0][CNT_W-1:0] iteration_count_field;
	} sog_template_t;

	typedef struct packed {
		sog_op_t op;
		logic [GEN_W-1:0] gen;
		logic [LVL_W-1:0] levels;
		sog_template_t tmpl;
	} sog_ctl_t;

	typedef struct packed {
		logic valid;
		sog_cls_t cls;
		logic [2:0] mode;
		logic [OFFREG_W-1:0] offreg;
		logic pred;
		logic [1:0] esize_log2;
		logic base_global;
		logic [ADDR_W-1:0] local_base;
		logic [ADDR_W-1:0] global_base;
	} sog_acc_t;

	typedef struct packed {
		logic valid;
		logic gen_ref;
		logic fault;
		logic [ADDR_W-1:0] addr;
	} sog_res_t;
endpackage : sog_pkg

// ===== src/sog_gen.sv
`timescale 1ns/1ps
`default_nettype none
module sog_gen (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic open_i,
	input wire logic close_i,
	input wire sog_pkg::sog_template_t tmpl_i,
	input wire logic brk_i,
	input wire logic [sog_pkg::LVL_W-1:0] brk_lvls_i,
	input wire logic adv_i,
	output logic active_o,
	output logic signed [sog_pkg::ADDR_W-1:0] offset_o,
	output logic ended_o
);
	sog_pkg::sog_template_t tmpl_q;
	logic active_q;
	logic done_q;
	logic [sog_pkg::LEVELS-1:0][sog_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic [sog_pkg::LEVELS-1:0][sog_pkg::ADDR_W-1:0] pos_q, pos_d;
	logic done_d;
	logic found;
	logic [2:0] start_lvl;
	logic [sog_pkg::LVL_W-1:0] hit_lvl;
	logic [sog_pkg::CNT_W-1:0] step;
	logic [sog_pkg::CNT_W-1:0] dec;
	logic [sog_pkg::ADDR_W-1:0] stride;
	logic [sog_pkg::ADDR_W-1:0] new_pos;

	// next position: lowest level at or above start_lvl with room takes the step
	always_comb begin
		found = 1'b0;
		new_pos = '0;
		cnt_d = cnt_q;
		pos_d = pos_q;
		step = sog_pkg::CNT_W'(1) << tmpl_q.vec_step;
		start_lvl = brk_i ? brk_lvls_i : sog_pkg::BRK_NONE;
		hit_lvl = '0;
		dec = '0;
		stride = '0;
		for (int l = 0; l < sog_pkg::LEVELS; l++) begin
			dec = (l == 0) ? step : sog_pkg::CNT_W'(1);
			stride = (l == 0) ? sog_pkg::ADDR_W'(step) : sog_pkg::ADDR_W'($signed(tmpl_q.dim[(l == 0) ? 1 : l]));
			if (!found && l >= int'(start_lvl) && l <= int'(tmpl_q.dim_fmt) && cnt_q[l] > dec) begin
				found = 1'b1;
				hit_lvl = sog_pkg::LVL_W'(l);
				cnt_d[l] = cnt_q[l] - dec;
				new_pos = pos_q[l] + stride;
				pos_d[l] = new_pos;
			end
		end
		// inner levels restart with full counts at the new position; outer levels keep theirs
		for (int l = 0; l < sog_pkg::LEVELS; l++) begin
			if (found && l < int'(hit_lvl)) begin
				cnt_d[l] = tmpl_q.iteration_count_field[l];
				pos_d[l] = new_pos;
			end
		end
		done_d = !found || (brk_i && brk_lvls_i == sog_pkg::BRK_FULL);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || close_i) begin
			tmpl_q <= '0;
			active_q <= 1'b0;
		end else if (open_i) begin
			tmpl_q <= tmpl_i;
			active_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		ended_o <= 1'b0;
		if (rst_i || close_i) begin
			cnt_q <= '0;
			pos_q <= '0;
			done_q <= 1'b0;
		end else if (open_i) begin
			cnt_q <= tmpl_i.iteration_count_field;
			pos_q <= '0;
			done_q <= 1'b0;
		end else if (active_q && !done_q && (adv_i || (brk_i && brk_lvls_i != sog_pkg::BRK_NONE))) begin
			cnt_q <= cnt_d;
			pos_q <= pos_d;
			done_q <= done_d;
			ended_o <= done_d;
		end
	end

	assign active_o = active_q;
	assign offset_o = done_q ? '0 : $signed(pos_q[0]);
endmodule : sog_gen
`default_nettype wire

// ===== src/sog_top.sv
// Functional notes
// - Four identical generators 0..3, each with its own template and loop count state.
// - Only load, store and scaled add/sub address instructions may name a generator.
// - The offset is scaled by the element size of the consuming opcode and added to the base, or subtracted from it for scaled sub.
// - The base comes from a local data-unit register or a global scalar register.
// - Modes 010 and 110 with offset field 0..3 take their offset from generator 0..3.
// - Open copies the template, loads the counts and sets the active bit.
// - Close restores template and counts to default and clears the active bit.
// - Referencing a closed generator is illegal.
// - Opening an open generator restarts from the new template.
// - Break takes generator 0..3 and 1..5 levels and skips those inner levels.
// - A five-level break ends the sequence but leaves the generator open.
// - An advance drops the inner count by the vector step and rolls to the next level at zero.
// - A false predicate leaves the generator position unchanged.
// - A generator advances at most once per cycle.
// - Past its last offset a generator returns zero.
`timescale 1ns/1ps
`default_nettype none
module sog_top #(
	parameter int NUM_SLOTS = 2
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic CTL_VALID_I,
	input wire sog_pkg::sog_ctl_t CTL_I,
	input wire sog_pkg::sog_acc_t [NUM_SLOTS-1:0] ACC_I,
	output sog_pkg::sog_res_t [NUM_SLOTS-1:0] RES_O,
	output logic [sog_pkg::NUM_GEN-1:0] GEN_ACTIVE_O,
	output logic IRQ_O,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [sog_pkg::PADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR
);
	logic [sog_pkg::NUM_GEN-1:0] open_g, close_g, brk_g, adv_g, active_g, ended_g, fault_ev;
	logic signed [sog_pkg::ADDR_W-1:0] offset_g [sog_pkg::NUM_GEN];
	logic [NUM_SLOTS-1:0] ref_s, adv_s, bad_s;
	logic [sog_pkg::GEN_W-1:0] sel_s [NUM_SLOTS];
	logic [sog_pkg::IRQ_W-1:0] irq_stat_q, irq_mask_q;
	logic [15:0] fault_cnt_q;
	logic wr_en, rd_en, mapped;

	// control instruction decode
	always_comb begin
		open_g = '0;
		close_g = '0;
		brk_g = '0;
		if (CTL_VALID_I) begin
			unique case (CTL_I.op)
				sog_pkg::SOG_OP_OPEN: open_g[CTL_I.gen] = 1'b1;
				sog_pkg::SOG_OP_CLOSE: close_g[CTL_I.gen] = 1'b1;
				sog_pkg::SOG_OP_BREAK: brk_g[CTL_I.gen] = 1'b1;
				sog_pkg::SOG_OP_NONE: ;
			endcase
		end
	end

	// per-slot decode of generator references
	always_comb begin
		for (int s = 0; s < NUM_SLOTS; s++) begin
			sel_s[s] = ACC_I[s].offreg[sog_pkg::GEN_W-1:0];
			ref_s[s] = ACC_I[s].valid && ACC_I[s].offreg <= sog_pkg::OFFREG_GEN_LAST
				&& (ACC_I[s].mode == sog_pkg::MODE_SCALED || ACC_I[s].mode == sog_pkg::MODE_ADVANCE);
			bad_s[s] = ref_s[s] && (ACC_I[s].cls == sog_pkg::SOG_CLS_OTHER || !active_g[sel_s[s]]);
			adv_s[s] = ref_s[s] && !bad_s[s] && ACC_I[s].pred && ACC_I[s].mode == sog_pkg::MODE_ADVANCE;
		end
	end

	always_comb begin
		adv_g = '0;
		fault_ev = '0;
		for (int s = 0; s < NUM_SLOTS; s++) begin
			if (adv_s[s]) begin
				adv_g[sel_s[s]] = 1'b1;
			end
			if (bad_s[s]) begin
				fault_ev[sel_s[s]] = 1'b1;
			end
		end
	end

	for (genvar g = 0; g < sog_pkg::NUM_GEN; g++) begin : g_gen
		sog_gen u_gen (
			.clk_i(CLK_I),
			.rst_i(RST_I),
			.open_i(open_g[g]),
			.close_i(close_g[g]),
			.tmpl_i(CTL_I.tmpl),
			.brk_i(brk_g[g]),
			.brk_lvls_i(CTL_I.levels),
			.adv_i(adv_g[g]),
			.active_o(active_g[g]),
			.offset_o(offset_g[g]),
			.ended_o(ended_g[g])
		);
	end

	// address formation, registered one cycle after the request
	always_ff @(posedge CLK_I) begin
		for (int s = 0; s < NUM_SLOTS; s++) begin
			if (RST_I) begin
				RES_O[s] <= '0;
			end else begin
				RES_O[s].valid <= ACC_I[s].valid;
				RES_O[s].gen_ref <= ref_s[s];
				RES_O[s].fault <= bad_s[s];
				if (!ref_s[s] || bad_s[s]) begin
					RES_O[s].addr <= '0;
				end else begin
					if (ACC_I[s].cls == sog_pkg::SOG_CLS_SUBA) begin
						RES_O[s].addr <= (ACC_I[s].base_global ? ACC_I[s].global_base : ACC_I[s].local_base)
							- (offset_g[sel_s[s]] <<< ACC_I[s].esize_log2);
					end else begin
						RES_O[s].addr <= (ACC_I[s].base_global ? ACC_I[s].global_base : ACC_I[s].local_base)
							+ (offset_g[sel_s[s]] <<< ACC_I[s].esize_log2);
					end
				end
			end
		end
	end

	assign GEN_ACTIVE_O = active_g;

	// APB slave: zero wait states, unmapped addresses answer with an error
	assign PREADY = 1'b1;
	assign wr_en = PSEL && PENABLE && PWRITE;
	assign rd_en = PSEL && !PWRITE;
	assign mapped = PADDR == sog_pkg::REG_ACTIVE || PADDR == sog_pkg::REG_IRQ_STAT
		|| PADDR == sog_pkg::REG_IRQ_MASK || PADDR == sog_pkg::REG_FAULT_CNT;
	assign PSLVERR = PSEL && PENABLE && !mapped;

	// sticky events; a new event beats a same-cycle write-one clear
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			irq_stat_q <= sog_pkg::IRQ_STAT_RST;
		end else begin
			irq_stat_q <= (irq_stat_q & ~((wr_en && PADDR == sog_pkg::REG_IRQ_STAT)
				? PWDATA[sog_pkg::IRQ_W-1:0] : '0)) | {ended_g, fault_ev};
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			irq_mask_q <= sog_pkg::IRQ_MASK_RST;
		end else if (wr_en && PADDR == sog_pkg::REG_IRQ_MASK) begin
			irq_mask_q <= PWDATA[sog_pkg::IRQ_W-1:0];
		end
	end

	// saturating count of cycles with an illegal reference, written to clear
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			fault_cnt_q <= sog_pkg::FAULT_CNT_RST;
		end else if (|fault_ev && fault_cnt_q != 16'hFFFF) begin
			fault_cnt_q <= fault_cnt_q + 16'h0001;
		end else if (wr_en && PADDR == sog_pkg::REG_FAULT_CNT) begin
			fault_cnt_q <= sog_pkg::FAULT_CNT_RST;
		end
	end

	assign IRQ_O = |(irq_stat_q & irq_mask_q);

	// read data registered in the setup cycle so it stands through access
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			PRDATA <= 32'h0000_0000;
		end else if (rd_en && !PENABLE) begin
			unique case (PADDR)
				sog_pkg::REG_ACTIVE: PRDATA <= {28'h0000000, active_g};
				sog_pkg::REG_IRQ_STAT: PRDATA <= {24'h000000, irq_stat_q};
				sog_pkg::REG_IRQ_MASK: PRDATA <= {24'h000000, irq_mask_q};
				sog_pkg::REG_FAULT_CNT: PRDATA <= {16'h0000, fault_cnt_q};
				default: PRDATA <= 32'h0000_0000;
			endcase
		end
	end
endmodule : sog_top
`default_nettype wire

// ===== testbench/sog_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sog_monitor #(
	parameter int NUM_SLOTS = 2
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic CTL_VALID_I,
	input wire sog_pkg::sog_ctl_t CTL_I,
	input wire sog_pkg::sog_acc_t [NUM_SLOTS-1:0] ACC_I,
	input wire sog_pkg::sog_res_t [NUM_SLOTS-1:0] RES_O,
	input wire logic [sog_pkg::NUM_GEN-1:0] GEN_ACTIVE_O,
	input wire logic IRQ_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	a_res_next: assert property (
		ACC_I[0].valid |=> RES_O[0].valid) else $error("access gave no result");
	a_fault_zero: assert property (
		RES_O[0].fault |-> RES_O[0].addr == '0) else $error("fault with address");
	a_other_fault: assert property (
		ACC_I[0].valid && ACC_I[0].cls == sog_pkg::SOG_CLS_OTHER
		&& ACC_I[0].offreg <= sog_pkg::OFFREG_GEN_LAST
		&& (ACC_I[0].mode == sog_pkg::MODE_SCALED || ACC_I[0].mode == sog_pkg::MODE_ADVANCE)
		|=> RES_O[0].fault) else $error("class not refused");
	a_open_sets: assert property (
		CTL_VALID_I && CTL_I.op == sog_pkg::SOG_OP_OPEN |=> GEN_ACTIVE_O[$past(CTL_I.gen)])
		else $error("open left generator idle");
	a_close_clears: assert property (
		CTL_VALID_I && CTL_I.op == sog_pkg::SOG_OP_CLOSE |=> !GEN_ACTIVE_O[$past(CTL_I.gen)])
		else $error("close left generator active");
	a_break_stays: assert property (
		CTL_VALID_I && CTL_I.op == sog_pkg::SOG_OP_BREAK && GEN_ACTIVE_O[CTL_I.gen]
		|=> GEN_ACTIVE_O[$past(CTL_I.gen)]) else $error("break closed generator");
	a_closed_fault: assert property (
		ACC_I[0].valid && ACC_I[0].mode == sog_pkg::MODE_SCALED && !CTL_VALID_I
		&& ACC_I[0].offreg <= sog_pkg::OFFREG_GEN_LAST && !GEN_ACTIVE_O[ACC_I[0].offreg[1:0]]
		|=> RES_O[0].fault) else $error("closed generator gave offset");
	a_reset_idle: assert property (
		disable iff (1'b0) RST_I |=> GEN_ACTIVE_O == '0 && !IRQ_O) else $error("reset left state");
	c_advance: cover property (ACC_I[0].valid && ACC_I[0].mode == sog_pkg::MODE_ADVANCE && ACC_I[0].pred);
	c_full_break: cover property (CTL_VALID_I && CTL_I.op == sog_pkg::SOG_OP_BREAK && CTL_I.levels == 3'h5);
	c_irq: cover property (IRQ_O);
endmodule : sog_monitor
bind sog_top sog_monitor #(.NUM_SLOTS(NUM_SLOTS)) sog_monitor_inst (.CLK_I(CLK_I), .RST_I(RST_I),
	.CTL_VALID_I(CTL_VALID_I), .CTL_I(CTL_I), .ACC_I(ACC_I), .RES_O(RES_O), .GEN_ACTIVE_O(GEN_ACTIVE_O),
	.IRQ_O(IRQ_O));
`default_nettype wire

// ===== testbench/sog_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module sog_cpu_model (
	input wire logic clk_i,
	output logic ctl_valid_o,
	output sog_pkg::sog_ctl_t ctl_o,
	output sog_pkg::sog_acc_t [1:0] acc_o
);
	initial begin
		ctl_valid_o = 1'b0;
		ctl_o = '0;
		acc_o = '0;
	end
	// one control op held for a single edge
	task automatic ctl(input sog_pkg::sog_op_t op, input int g, input int lv, input sog_pkg::sog_template_t t);
		@(posedge clk_i);
		ctl_valid_o <= 1'b1;
		ctl_o <= '{op, g[1:0], lv[2:0], t};
		@(posedge clk_i);
		ctl_valid_o <= 1'b0;
	endtask : ctl
	task automatic acc(input sog_pkg::sog_acc_t a0, input sog_pkg::sog_acc_t a1);
		@(posedge clk_i);
		acc_o <= {a1, a0};
		@(posedge clk_i);
		acc_o <= '0;
	endtask : acc
endmodule : sog_cpu_model
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk, rst, psel, pen, pwr, prdy, perr, irq, cv;
	logic [11:0] padr;
	logic [31:0] pwd, prd;
	sog_pkg::sog_ctl_t ctl;
	sog_pkg::sog_acc_t [1:0] acc;
	sog_pkg::sog_res_t [1:0] res;
	logic [3:0] act;
	int bad_count, total_checks, fc, pos[4], n0[4], n[4], stp[4], dm[4];
	bit op[4];
	sog_top sog_top_inst (.CLK_I(clk), .RST_I(rst), .CTL_VALID_I(cv), .CTL_I(ctl), .ACC_I(acc), .RES_O(res),
		.GEN_ACTIVE_O(act), .IRQ_O(irq), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr),
		.PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr));
	sog_cpu_model sog_cpu_model_inst (.clk_i(clk), .ctl_valid_o(cv), .ctl_o(ctl), .acc_o(acc));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	task automatic chk_val(input string s, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk_val
	task automatic chk_res(input logic f, input logic [63:0] a);
		chk_val("valid", 1, res[0].valid);
		chk_val("gen_ref", 1, res[0].gen_ref);
		chk_val("fault", f, res[0].fault);
		chk_val("addr", a, res[0].addr);
	endtask : chk_res
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		r = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	function automatic longint off(int g);
		int i, j;
		i = pos[g] / n0[g];
		j = pos[g] % n0[g];
		return (op[g] && pos[g] < n[g]) ? i * dm[g] + j * stp[g] : 0;
	endfunction : off
	task automatic opn(input int g, input int s, input int a0, input int a1, input int d);
		sog_pkg::sog_template_t t;
		t = '0;
		t.vec_step = 3'(s);
		t.dim_fmt = 3'h1;
		t.dim[1] = 32'(d);
		t.iteration_count_field[0] = 32'(a0);
		t.iteration_count_field[1] = 32'(a1);
		sog_cpu_model_inst.ctl(sog_pkg::SOG_OP_OPEN, g, 0, t);
		op[g] = 1;
		pos[g] = 0;
		stp[g] = 1 << s;
		n0[g] = a0 >> s;
		n[g] = n0[g] * a1;
		dm[g] = d;
		#1;
		chk_val("active", 1, act[g]);
	endtask : opn
	task automatic go(input int g, input logic [2:0] m, input logic p, input int c, input bit two);
		sog_pkg::sog_acc_t a;
		logic [63:0] b, sh, x;
		logic f;
		a = '{1'b1, sog_pkg::sog_cls_t'(c), m, 5'(g), p, 2'($urandom), 1'($urandom),
			64'($urandom) << 8, 64'($urandom) << 8};
		sh = 64'(off(g)) << a.esize_log2;
		b = a.base_global ? a.global_base : a.local_base;
		f = c == 4 || !op[g];
		x = f ? 64'h0 : (c == 3 ? b - sh : b + sh);
		sog_cpu_model_inst.acc(a, two ? a : '0);
		#1;
		chk_res(f, x);
		chk_val("valid1", two, res[1].valid);
		chk_val("fault1", two && f, res[1].fault);
		chk_val("addr1", two ? x : 64'h0, res[1].addr);
		fc += f;
		// a doubled request still moves the generator once
		if (m == 3'h6 && p && !f)
			pos[g]++;
	endtask : go
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		summarize();
	end
	initial begin
		int k;
		logic [31:0] r;
		logic e;
		sog_pkg::sog_acc_t a;
		{psel, pen, pwr, padr, pwd} = '0;
		void'($urandom(32'hA444D003));
		rst = 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk_val("active", 0, act);
		for (int g = 0; g < 4; g++) begin
			opn(g, $urandom % 3, 8, 2, 32);
			go(g, 3'h2, 1'b1, 0, 1'b0);
			k = 0;
			while (pos[g] <= n[g] && k < 40) begin
				go(g, 3'h6, 1'($urandom), $urandom % 4, k[0]);
				k++;
			end
		end
		go(0, 3'h6, 1'b1, 4, 1'b0);
		opn(0, 0, 4, 1, 0);
		repeat (2) go(0, 3'h6, 1'b1, 1, 1'b0);
		for (int l = 1; l < 6; l++) begin
			opn(1, 0, 4, 2, 16);
			go(1, 3'h6, 1'b1, 0, 1'b0);
			sog_cpu_model_inst.ctl(sog_pkg::SOG_OP_BREAK, 1, l, '0);
			pos[1] = l == 1 ? n0[1] : n[1];
			go(1, 3'h6, 1'b1, 2, 1'b0);
			chk_val("active", 1, act[1]);
		end
		// an offset field naming a plain register is no generator reference
		a = '0;
		a.valid = 1'b1;
		a.mode = sog_pkg::MODE_SCALED;
		a.offreg = 5'h10;
		a.local_base = 64'($urandom);
		sog_cpu_model_inst.acc(a, '0);
		#1;
		chk_val("plain_ref", 0, res[0].gen_ref);
		chk_val("plain_addr", 0, res[0].addr);
		apb(1, sog_pkg::REG_IRQ_STAT, 32'h000000FF, r, e);
		sog_cpu_model_inst.ctl(sog_pkg::SOG_OP_CLOSE, 2, 0, '0);
		op[2] = 0;
		#1;
		chk_val("active", 0, act[2]);
		go(2, 3'h2, 1'b1, 0, 1'b0);
		apb(0, sog_pkg::REG_ACTIVE, 0, r, e);
		chk_val("act_reg", {op[3], op[2], op[1], op[0]}, r);
		chk_val("slverr", 0, e);
		apb(0, sog_pkg::REG_IRQ_STAT, 0, r, e);
		chk_val("stat", 32'h00000004, r);
		chk_val("irq", 0, irq);
		apb(1, sog_pkg::REG_IRQ_MASK, 32'h00000004, r, e);
		#1;
		chk_val("irq", 1, irq);
		apb(1, sog_pkg::REG_IRQ_STAT, 32'h00000004, r, e);
		#1;
		chk_val("irq", 0, irq);
		apb(0, sog_pkg::REG_FAULT_CNT, 0, r, e);
		chk_val("fault_cnt", fc, r[15:0]);
		apb(0, 12'h010, 0, r, e);
		chk_val("slverr", 1, e);
		chk_val("rdata", 0, r);
		// a fresh fault raises the line, then a mid-run reset must close everything
		go(2, 3'h2, 1'b1, 1, 1'b0);
		chk_val("irq", 1, irq);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk_val("active", 0, act);
		chk_val("irq", 0, irq);
		apb(0, sog_pkg::REG_FAULT_CNT, 0, r, e);
		chk_val("fault_cnt", 0, r);
		summarize();
	end
endmodule : testbench
`default_nettype wire
